// ---- amas_pkg.sv ----
// package: shared types and constants for the async memory access sequencer
package amas_pkg;

	localparam int NUM_SPACES  = 4;
	localparam int CS_W        = 2;
	localparam int ADDR_W      = 22;
	localparam int SETUP_W     = 4;
	localparam int STROBE_W    = 6;
	localparam int HOLD_W      = 3;
	localparam int TA_W        = 2;
	localparam int FIFO_DEPTH  = 16;
	localparam int CNT_W       = 6;
	localparam logic [1:0] LAST_LANE = 2'h3;
	localparam logic [7:0] PARK_RESET = 8'h00;

	// one internal access request
	typedef struct packed {
		logic              write;
		logic [CS_W-1:0]   space;
		logic [ADDR_W-1:0] word_addr;
		logic [3:0]        byte_en;
		logic [31:0]       wdata;
	} amas_req_t;

	localparam int REQ_W = $bits(amas_req_t);

	// timing settings of one chip-select space, each field is length minus one
	typedef struct packed {
		logic [SETUP_W-1:0]  w_setup;
		logic [STROBE_W-1:0] w_strobe;
		logic [HOLD_W-1:0]   w_hold;
		logic [SETUP_W-1:0]  r_setup;
		logic [STROBE_W-1:0] r_strobe;
		logic [HOLD_W-1:0]   r_hold;
		logic [TA_W-1:0]     turnaround_len;
	} amas_timing_t;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_TURN   = 6'b00_0010,
		ST_SETUP  = 6'b00_0100,
		ST_STROBE = 6'b00_1000,
		ST_HOLD   = 6'b01_0000,
		ST_DONE   = 6'b10_0000
	} amas_state_t;

endpackage

// ---- amas_fifo.sv ----
// synchronous request fifo with valid/ready on both sides
`timescale 1ns/1ps
module amas_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_ptr_reg, wr_ptr_next;
	logic [PW:0]      rd_ptr_reg, rd_ptr_next;
	logic             push, pop;
	logic             ready_reg, ready_next;

	// ready is kept in a flop so the ready output of the sequencer is registered
	always_comb begin
		in_ready    = ready_reg;
		out_valid   = wr_ptr_reg != rd_ptr_reg;
		out_data    = mem[rd_ptr_reg[PW-1:0]];
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		ready_next  = (wr_ptr_next - rd_ptr_next) != (PW+1)'(DEPTH);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			ready_reg  <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			ready_reg  <= ready_next;
		end
	end

	// storage has no reset; only the pointers define what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg[PW-1:0]] <= in_data;
		end
	end
endmodule

// ---- amas_sequencer.sv ----
// async memory access sequencer: 32-bit requests to ordered byte accesses on an 8-bit bus
// What this block does
// - on clock stop request, drain all pending transfers, then acknowledge
// - debug halt or breakpoint has no effect on any access
// - a read completes only after all earlier writes to its space finished
// - word splits into byte accesses, lowest byte address first
// - data bits 7:0..31:24 go out with byte address 0..3
// - only enabled lanes are accessed (all four if none enabled), ascending; full word gives four accesses
// - period lengths come from the accessed space's timing settings
// - separate read and write setup, strobe, hold; chosen by direction
// - each setting is length in cycles minus one
// - turnaround inserted after a read before driving write data
// - idle bus parks on last write data; released only during reads and turnaround
`timescale 1ns/1ps
module amas_sequencer (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                resetn,
	// timing settings per chip-select space
	input  wire amas_pkg::amas_timing_t              space_timing_config [amas_pkg::NUM_SPACES],
	// request side
	input  wire logic                                req_valid,
	output logic                                     req_ready,
	input  wire amas_pkg::amas_req_t                 req_data,
	// completion side
	output logic                                     done_valid,
	output logic                                     done_write,
	output logic [amas_pkg::CS_W-1:0]                done_space,
	output logic [31:0]                              done_rdata,
	// power sleep controller
	input  wire logic                                clk_stop_req,
	output logic                                     clk_stop_ack,
	// external memory pins
	output logic [amas_pkg::NUM_SPACES-1:0]          chip_select_n,
	output logic [amas_pkg::ADDR_W-1:0]              addr_lines,
	output logic [1:0]                               byte_address_lines,
	output logic                                     read_strobe_n,
	output logic                                     write_strobe_n,
	output logic [7:0]                               ext_byte_data_bus_o,
	output logic                                     ext_byte_data_bus_oe,
	input  wire logic [7:0]                          ext_byte_data_bus_i
);
	// request fifo
	logic                 fifo_valid, fifo_pop;
	amas_pkg::amas_req_t  fifo_req;
	logic [amas_pkg::REQ_W-1:0] fifo_out;

	amas_fifo #(
		.WIDTH(amas_pkg::REQ_W),
		.DEPTH(amas_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.resetn   (resetn),
		.in_valid (req_valid),
		.in_ready (req_ready),
		.in_data  (req_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data (fifo_out)
	);
	assign fifo_req = amas_pkg::amas_req_t'(fifo_out);

	// stop request passes a two-flop synchroniser
	logic stop_meta_reg, stop_sync_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stop_meta_reg <= 1'b0;
			stop_sync_reg <= 1'b0;
		end else begin
			stop_meta_reg <= clk_stop_req;
			stop_sync_reg <= stop_meta_reg;
		end
	end

	amas_pkg::amas_state_t state_reg, state_next;
	amas_pkg::amas_req_t   cur_reg, cur_next;
	amas_pkg::amas_timing_t tim;
	logic [1:0]  lane_reg, lane_next;
	logic [3:0]  left_reg, left_next;
	logic [amas_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        last_read_reg, last_read_next;
	logic [7:0]  park_reg, park_next;
	logic        done_valid_next, ack_next;
	logic [1:0]  first_lane, next_lane;
	logic [3:0]  left_after;
	logic [amas_pkg::CNT_W-1:0] setup_len, strobe_len, hold_len, ta_len;

	// lowest enabled lane of a mask
	function automatic logic [1:0] low_lane(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	always_comb begin
		tim        = space_timing_config[cur_reg.space];
		// read and write settings chosen by direction
		setup_len  = cur_reg.write ? amas_pkg::CNT_W'(tim.w_setup)  : amas_pkg::CNT_W'(tim.r_setup);
		strobe_len = cur_reg.write ? amas_pkg::CNT_W'(tim.w_strobe) : amas_pkg::CNT_W'(tim.r_strobe);
		hold_len   = cur_reg.write ? amas_pkg::CNT_W'(tim.w_hold)   : amas_pkg::CNT_W'(tim.r_hold);
		ta_len     = amas_pkg::CNT_W'(tim.turnaround_len);
		left_after = left_reg & ~(4'h1 << lane_reg);
		next_lane  = low_lane(left_after);
		first_lane = low_lane(fifo_req.byte_en);

		state_next      = state_reg;
		cur_next        = cur_reg;
		lane_next       = lane_reg;
		left_next       = left_reg;
		cnt_next        = cnt_reg;
		rdata_next      = rdata_reg;
		last_read_next  = last_read_reg;
		park_next       = park_reg;
		done_valid_next = 1'b0;
		fifo_pop        = 1'b0;
		// accesses run strictly in arrival order, so a read cannot pass an earlier write
		// no halt input exists: debug events cannot alter an access
		ack_next        = stop_sync_reg && state_reg == amas_pkg::ST_IDLE && !fifo_valid;

		case (state_reg)
			amas_pkg::ST_IDLE: begin
				if (fifo_valid && !ack_next && !clk_stop_ack) begin
					fifo_pop   = 1'b1;
					cur_next   = fifo_req;
					left_next  = fifo_req.byte_en == 4'h0 ? 4'hF : fifo_req.byte_en;
					lane_next  = fifo_req.byte_en == 4'h0 ? 2'h0 : first_lane;
					rdata_next = 32'h0000_0000;
					cnt_next   = '0;
					if (fifo_req.write && last_read_reg) begin
						state_next = amas_pkg::ST_TURN;
					end else begin
						state_next = amas_pkg::ST_SETUP;
					end
				end
			end
			amas_pkg::ST_TURN: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == ta_len) begin
					cnt_next       = '0;
					last_read_next = 1'b0;
					state_next     = amas_pkg::ST_SETUP;
				end
			end
			amas_pkg::ST_SETUP: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == setup_len) begin
					cnt_next   = '0;
					state_next = amas_pkg::ST_STROBE;
				end
			end
			amas_pkg::ST_STROBE: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == strobe_len) begin
					cnt_next   = '0;
					state_next = amas_pkg::ST_HOLD;
					if (!cur_reg.write) begin
						rdata_next[lane_reg*8 +: 8] = ext_byte_data_bus_i;
					end
				end
			end
			amas_pkg::ST_HOLD: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == hold_len) begin
					cnt_next       = '0;
					last_read_next = !cur_reg.write;
					if (cur_reg.write) begin
						park_next = cur_reg.wdata[lane_reg*8 +: 8];
					end
					left_next = left_after;
					lane_next = next_lane;
					if (left_after == 4'h0) begin
						state_next = amas_pkg::ST_DONE;
					end else begin
						// lanes of one request share a direction, so no turnaround inside a request
						state_next = amas_pkg::ST_SETUP;
					end
				end
			end
			amas_pkg::ST_DONE: begin
				done_valid_next = 1'b1;
				state_next      = amas_pkg::ST_IDLE;
			end
			default: begin
				state_next = amas_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= amas_pkg::ST_IDLE;
			cur_reg       <= '0;
			lane_reg      <= 2'h0;
			left_reg      <= 4'h0;
			cnt_reg       <= '0;
			rdata_reg     <= 32'h0000_0000;
			last_read_reg <= 1'b0;
			park_reg      <= amas_pkg::PARK_RESET;
			done_valid    <= 1'b0;
			clk_stop_ack  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cur_reg       <= cur_next;
			lane_reg      <= lane_next;
			left_reg      <= left_next;
			cnt_reg       <= cnt_next;
			rdata_reg     <= rdata_next;
			last_read_reg <= last_read_next;
			park_reg      <= park_next;
			done_valid    <= done_valid_next;
			clk_stop_ack  <= ack_next;
		end
	end

	// pin registers, loaded from the next state so they change with the state and every output is a flop
	logic active_next;
	always_comb begin
		active_next = state_next == amas_pkg::ST_SETUP || state_next == amas_pkg::ST_STROBE ||
			state_next == amas_pkg::ST_HOLD;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chip_select_n        <= '1;
			addr_lines           <= '0;
			byte_address_lines   <= 2'h0;
			read_strobe_n        <= 1'b1;
			write_strobe_n       <= 1'b1;
			ext_byte_data_bus_o  <= amas_pkg::PARK_RESET;
			ext_byte_data_bus_oe <= 1'b1;
			done_write           <= 1'b0;
			done_space           <= '0;
			done_rdata           <= 32'h0000_0000;
		end else begin
			chip_select_n        <= active_next ? ~(amas_pkg::NUM_SPACES'(1) << cur_next.space) : '1;
			addr_lines           <= cur_next.word_addr;
			byte_address_lines   <= lane_next;
			read_strobe_n        <= !(state_next == amas_pkg::ST_STROBE && !cur_next.write);
			write_strobe_n       <= !(state_next == amas_pkg::ST_STROBE && cur_next.write);
			ext_byte_data_bus_o  <= (active_next && cur_next.write) ? cur_next.wdata[lane_next*8 +: 8] : park_next;
			// released only while a read access runs or during turnaround
			ext_byte_data_bus_oe <= !((active_next && !cur_next.write) || state_next == amas_pkg::ST_TURN);
			if (state_reg == amas_pkg::ST_DONE) begin
				done_write <= cur_reg.write;
				done_space <= cur_reg.space;
				done_rdata <= rdata_reg;
			end
		end
	end
endmodule

// ---- amas_seq_chk_sva.sv ----
// pin-level assertions for the sequencer
`timescale 1ns/1ps
module amas_seq_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// pins watched
	input wire logic [3:0] chip_select_n,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic       ext_byte_data_bus_oe,
	input wire logic       clk_stop_req,
	input wire logic       clk_stop_ack
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_rd_start; $fell(read_strobe_n); endsequence
	sequence s_wr_end; $rose(write_strobe_n); endsequence
	a_strobe_in_cs: assert property ((!read_strobe_n || !write_strobe_n) |-> chip_select_n != 4'hf)
		else $error("strobe without select");
	a_one_strobe: assert property (read_strobe_n || write_strobe_n)
		else $error("both strobes low");
	a_one_space: assert property ($onehot0(~chip_select_n))
		else $error("two spaces selected");
	a_read_release: assert property (!read_strobe_n |-> !ext_byte_data_bus_oe)
		else $error("bus driven in read");
	a_write_drive: assert property (!write_strobe_n |-> ext_byte_data_bus_oe)
		else $error("bus not driven in write");
	a_setup_first: assert property (s_rd_start |-> $past(chip_select_n) != 4'hf)
		else $error("no setup before strobe");
	a_hold_after: assert property (s_wr_end |-> chip_select_n != 4'hf)
		else $error("no hold after strobe");
	a_ack_idle: assert property (clk_stop_ack |-> chip_select_n == 4'hf)
		else $error("access while acknowledged");
	// request passes two sync flops and the ack flop, so it is seen three edges back
	a_ack_cause: assert property ($rose(clk_stop_ack) |-> $past(clk_stop_req, 3))
		else $error("ack without request");
endmodule
bind amas_sequencer amas_seq_chk i_chk (.clk(clk), .resetn(resetn), .chip_select_n(chip_select_n),
	.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.ext_byte_data_bus_oe(ext_byte_data_bus_oe), .clk_stop_req(clk_stop_req), .clk_stop_ack(clk_stop_ack));

// ---- amas_sram_model.sv ----
// byte wide sram on the far side of the pins
`timescale 1ns/1ps
module amas_sram_model (
	// pins from the sequencer
	input wire logic       clk,
	input wire logic [3:0] chip_select_n,
	input wire logic [1:0] byte_address_lines,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic [7:0] wr_data,
	// read data toward the bus
	output logic     [7:0] rd_data
);
	logic [7:0] mem [4][4];
	logic [7:0] junk = 8'h5a;
	int         sp;
	always_comb begin
		sp = 0;
		for (int i = 0; i < 4; i++) if (!chip_select_n[i]) sp = i;
	end
	// one cell per lane and space: the word address is not decoded
	always @(posedge clk) begin
		junk <= ~junk + 8'h01;
		if (!write_strobe_n && chip_select_n != 4'hf) mem[sp][byte_address_lines] <= wr_data;
	end
	// a released bus shows a moving pattern, never the last value
	assign rd_data = (!read_strobe_n && chip_select_n != 4'hf) ? mem[sp][byte_address_lines] : junk;
endmodule

// ---- amas_sequencer_test.sv ----
// self-checking bench for the sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module amas_sequencer_test;
	logic                   clk = 0;
	logic                   resetn = 0;
	amas_pkg::amas_timing_t cfg [amas_pkg::NUM_SPACES];
	logic                   req_valid = 0, req_ready;
	amas_pkg::amas_req_t    req_data = '0;
	logic                   done_valid, done_write, clk_stop_req = 0, clk_stop_ack;
	logic [1:0]             done_space, lane;
	logic [31:0]            done_rdata;
	logic [3:0]             cs_n;
	logic [21:0]            addr;
	logic                   rd_n, wr_n, oe;
	logic [7:0]             d_o, d_i, mem_d;
	int                     mismatches = 0, comparisons = 0, st_len = 0, since_rd = 0, wgap = 0;
	logic [1:0]             lane_q[$];
	logic [7:0]             data_q[$];
	int                     len_q[$];
	always #12.5 clk = ~clk;
	assign d_i = oe ? d_o : mem_d;
	initial cfg = '{'{default:'0}, '{4'h2, 6'h03, 3'h1, 4'h1, 6'h00, 3'h2, 2'h3}, '{4'h0, 6'h05, 3'h0, 4'h0, 6'h00,
		3'h0, 2'h0}, '{default:'0}};
	amas_sequencer i_dut (.clk(clk), .resetn(resetn), .space_timing_config(cfg), .req_valid(req_valid),
		.req_ready(req_ready), .req_data(req_data), .done_valid(done_valid), .done_write(done_write),
		.done_space(done_space), .done_rdata(done_rdata), .clk_stop_req(clk_stop_req), .clk_stop_ack(clk_stop_ack),
		.chip_select_n(cs_n), .addr_lines(addr), .byte_address_lines(lane), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .ext_byte_data_bus_o(d_o), .ext_byte_data_bus_oe(oe), .ext_byte_data_bus_i(d_i));
	amas_sram_model i_mem (.clk(clk), .chip_select_n(cs_n), .byte_address_lines(lane), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .wr_data(d_o), .rd_data(mem_d));
	// logs lane, data and strobe length of every byte access
	always @(posedge clk) begin
		if (!rd_n || !wr_n) begin
			if (st_len == 0) begin
				lane_q.push_back(lane);
				data_q.push_back(d_o);
				if (!wr_n) wgap = since_rd;
			end
			st_len++;
		end else if (st_len != 0) begin
			len_q.push_back(st_len);
			st_len = 0;
		end
		since_rd = rd_n ? since_rd + 1 : 0;
	end
	task automatic tally_and_finish(input bit hung);
		if (hung) mismatches++;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic push(input logic w, input logic [1:0] sp, input logic [3:0] be, input logic [31:0] d);
		int n;
		req_valid = 1;
		req_data = '{w, sp, 22'h00_0010, be, d};
		for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk);
		if (n == 200) tally_and_finish(1);
		@(negedge clk);
	endtask
	task automatic wait_done(input logic w, input logic [1:0] sp, input logic [31:0] rd, input bit chk);
		int n;
		for (n = 0; n < 800 && done_valid !== 1'b1; n++) @(negedge clk);
		if (n == 800) tally_and_finish(1);
		`CHK(done_write, w)
		`CHK(done_space, sp)
		if (chk) `CHK(done_rdata, rd)
		@(negedge clk);
	endtask
	task automatic clr();
		lane_q.delete();
		data_q.delete();
		len_q.delete();
	endtask
	task automatic sc_word();
		clr();
		push(1, 2'h1, 4'hf, 32'h789a_bcde);
		req_valid = 0;
		wait_done(1, 2'h1, 0, 0);
		for (int i = 0; i < 4; i++) begin
			`CHK(lane_q[i], 2'(i))
			`CHK(data_q[i], 8'(32'h789a_bcde >> (8 * i)))
			`CHK(len_q[i], 4)
		end
		// idle bus parks on the last byte written, address lines keep the request address
		`CHK(oe, 1'b1)
		`CHK(d_o, 8'h78)
		`CHK(addr, 22'h00_0010)
	endtask
	task automatic sc_lanes();
		clr();
		push(1, 2'h2, 4'ha, 32'h4433_2211);
		req_valid = 0;
		wait_done(1, 2'h2, 0, 0);
		`CHK(lane_q.size(), 2)
		`CHK(lane_q[0], 2'h1)
		`CHK(lane_q[1], 2'h3)
		`CHK(data_q[1], 8'h44)
		`CHK(len_q[0], 6)
	endtask
	// write, then a checked read back of the same space, then a write after the read
	task automatic sc_read_turn();
		clr();
		push(1, 2'h1, 4'hf, 32'h1122_3344);
		push(0, 2'h1, 4'hf, 32'h0);
		push(1, 2'h1, 4'h1, 32'h55);
		req_valid = 0;
		wait_done(1, 2'h1, 0, 0);
		wait_done(0, 2'h1, 32'h1122_3344, 1);
		wait_done(1, 2'h1, 0, 0);
		`CHK(len_q[4], 1)
		`CHK(len_q[8], 4)
		`CHK(wgap >= 10, 1'b1)
	endtask
	task automatic sc_stop();
		int n;
		int seen;
		push(1, 2'h2, 4'hf, 32'h0);
		push(1, 2'h2, 4'hf, 32'h0);
		req_valid = 0;
		clk_stop_req = 1;
		seen = 0;
		for (n = 0; n < 600 && clk_stop_ack !== 1'b1; n++) begin
			if (done_valid === 1'b1) seen++;
			@(negedge clk);
		end
		if (n == 600) tally_and_finish(1);
		`CHK(seen, 2)
		// the clock keeps running: gating is left to the power controller
		clk_stop_req = 0;
		repeat (6) @(negedge clk);
		`CHK(clk_stop_ack, 1'b0)
	endtask
	// slow writes stall the drain so the request buffer fills up
	task automatic sc_fill();
		int k;
		for (k = 0; k < 40 && req_ready === 1'b1; k++) push(1, 2'h2, 4'hf, 32'(k));
		req_valid = 0;
		`CHK(k >= 16 && k <= 17, 1'b1)
		for (int i = 0; i < k; i++) wait_done(1, 2'h2, 0, 0);
		`CHK(req_ready, 1'b1)
	endtask
	// pins and handshakes as reset leaves them
	task automatic sc_reset();
		`CHK(cs_n, 4'hf)
		`CHK(rd_n & wr_n, 1'b1)
		`CHK(oe, 1'b1)
		`CHK(d_o, 8'h00)
		`CHK(clk_stop_ack, 1'b0)
		`CHK(req_ready, 1'b1)
	endtask
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1;
		sc_reset();
		sc_word();
		sc_lanes();
		sc_read_turn();
		sc_stop();
		sc_fill();
		tally_and_finish(0);
	end
endmodule
